// File: logic/dpc_regs.svh
/*
  Register offsets, field positions, reset values and timing counts of
  the deserializer pin configuration control block.
  Assumes a 100 MHz pclk and a 32-bit APB bus.
*/
`ifndef DPC_REGS_SVH
`define DPC_REGS_SVH

`define DPC_ADDR_W 12
`define DPC_OFF_CTRL 12'h000
`define DPC_OFF_STATUS 12'h004
`define DPC_OFF_MASK 12'h008
`define DPC_OFF_STATE 12'h00C

// ctrl fields
`define DPC_CTRL_OVR 0
`define DPC_CTRL_MODE_LO 1
`define DPC_CTRL_MODE_HI 2
`define DPC_CTRL_BAND 3
`define DPC_CTRL_MAP 4
`define DPC_CTRL_SWING 5
`define DPC_CTRL_W 6
`define DPC_CTRL_RST 6'h00

// status and mask fields
`define DPC_EV_LOCK_UP 0
`define DPC_EV_LOCK_DOWN 1
`define DPC_EV_SPARE 2
`define DPC_EV_W 3
`define DPC_MASK_RST 3'h0

// state readback fields
`define DPC_ST_LOCK 0
`define DPC_ST_MODE_LO 1
`define DPC_ST_MODE_HI 2
`define DPC_ST_BAND 3
`define DPC_ST_MAP 4
`define DPC_ST_SWING 5
`define DPC_ST_SSC 6
`define DPC_ST_GAIN 7
`define DPC_ST_ACTIVE 8
`define DPC_ST_OE 9

// timing
`define DPC_CLK_PERIOD_NS 10
`define DPC_LOCK_SETTLE_NS 100
`define DPC_LOCK_SETTLE_CYC \
  ((`DPC_LOCK_SETTLE_NS + `DPC_CLK_PERIOD_NS - 1) / `DPC_CLK_PERIOD_NS)

`endif

// File: logic/dpc_pkg.sv
/*
  Types of the deserializer pin configuration control block.
  Assumes dpc_regs.svh for all numeric constants.
*/
package dpc_pkg;

  typedef enum logic [1:0] {
    DPC_MODE_CUR_NOFILT,
    DPC_MODE_CUR_FILT,
    DPC_MODE_LEGACY_A,
    DPC_MODE_LEGACY_B
  } dpc_mode_t;

  typedef struct packed {
    logic [5:0] ctrl;
    logic [2:0] status;
    logic [2:0] mask;
    logic [31:0] rdata;
    logic lock_prev;
    logic strap_done;
    logic gain;
    dpc_mode_t mode;
    logic filter_en;
    logic band;
    logic map;
    logic swing;
    logic ssc_en;
    logic [2:0] ssc_range;
    logic data_oe;
    logic irq;
  } dpc_state_t;

endpackage : dpc_pkg

// File: logic/dpc_lock_filt.sv
/*
  Lock status qualifier: lock_status rises after the receive PLL has
  reported lock for SETTLE consecutive cycles, and falls at once.
  Assumes pll_locked is synchronous to pclk.
*/
`timescale 1ns/1ps
`include "dpc_regs.svh"

module dpc_lock_filt import dpc_pkg::*; #(
  parameter int SETTLE = `DPC_LOCK_SETTLE_CYC,
  parameter int CNT_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic pll_locked,
  output logic lock_status
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic lock;
  } dpc_lf_t;

  localparam logic [CNT_W-1:0] SETTLE_C = CNT_W'(SETTLE);

  dpc_lf_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (!enable || !pll_locked) begin
      // drop at once: unlock must never be reported late
      st_d.cnt = '0;
    end else if (st_q.cnt != SETTLE_C) begin
      st_d.cnt = st_q.cnt + CNT_W'(1);
    end
    st_d.lock = enable && pll_locked && (st_d.cnt == SETTLE_C);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign lock_status = st_q.lock;

  property p_unlock_low;
    @(posedge pclk) disable iff (!presetn)
      !pll_locked |=> !lock_status;
  endproperty
  a_unlock_low: assert property (p_unlock_low)
    else $error("lock status high after pll unlock");

  property p_lock_rise;
    @(posedge pclk) disable iff (!presetn)
      $rose(lock_status) |-> $past(pll_locked) && $past(enable)
        && ($past(st_q.cnt) == SETTLE_C - CNT_W'(1));
  endproperty
  a_lock_rise: assert property (p_lock_rise)
    else $error("lock status rose without settled pll lock");

endmodule : dpc_lock_filt

// File: logic/dpc_lane_map.sv
/*
  Lane 3 bit mapper: places the upper or lower bit group on lane 3 and
  registers it; the lane reads zero while the device is powered down.
  Assumes both bit groups are synchronous to pclk.
*/
`timescale 1ns/1ps

module dpc_lane_map import dpc_pkg::*; #(
  parameter int W = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic active,
  input wire logic msb_first,
  input wire logic [W-1:0] msb_bits,
  input wire logic [W-1:0] lsb_bits,
  output logic [W-1:0] lane3
);

  typedef struct packed {
    logic [W-1:0] lane;
  } dpc_lm_t;

  dpc_lm_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (!active) begin
      st_d.lane = '0;
    end else begin
      st_d.lane = msb_first ? msb_bits : lsb_bits;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign lane3 = st_q.lane;

  property p_map_msb;
    @(posedge pclk) disable iff (!presetn)
      active && msb_first |=> lane3 == $past(msb_bits);
  endproperty
  a_map_msb: assert property (p_map_msb)
    else $error("lane 3 lacks upper bits");

  property p_map_lsb;
    @(posedge pclk) disable iff (!presetn)
      active && !msb_first |=> lane3 == $past(lsb_bits);
  endproperty
  a_map_lsb: assert property (p_map_lsb)
    else $error("lane 3 lacks lower bits");

endmodule : dpc_lane_map

// File: logic/dpc_top.sv
/*
  Pin level configuration and status control of a serial to parallel
  video deserializer, with an APB register file and one interrupt.
  Assumes all pins synchronous to pclk; analog blocks act on the levels.
*/
// Implementation choices: the register offsets and register access over APB.
// Behaviour
// - lock output high while pll locked; here raised only after SETTLE consecutive locked cycles while powered up
// - lock output low while pll unlocked
// - mode 00: current serializer, filter off
// - mode 01: current serializer, filter on
// - mode 10: older serializer family format
// - mode 11: other legacy serializer format
// - band pin high selects low ssc band
// - no spread spectrum above 65 MHz
// - map pin picks msb or lsb on lane3
// - power_down_n low powers device down
// - powered down: lvds data outputs released
// - power down resets control registers
// - three range pins select spread range
`timescale 1ns/1ps
`include "dpc_regs.svh"

module dpc_top import dpc_pkg::*; #(
  parameter int LANE_W = 7,
  parameter int SETTLE = `DPC_LOCK_SETTLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`DPC_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic [1:0] config_mode,
  input wire logic low_freq_band,
  input wire logic bit_map_order,
  input wire logic output_enable_pin,
  input wire logic sleep_state_select,
  input wire logic power_down_n,
  input wire logic spare_input_low,
  input wire logic [2:0] spread_range_select,
  input wire logic lvds_swing_select,
  input wire logic clk_above_65m,
  input wire logic pll_locked,
  input wire logic bist_pass,
  input wire logic gain_pass_i,
  output logic gain_pass_o,
  output logic gain_pass_oe,
  input wire logic [LANE_W-1:0] lane_msb_bits,
  input wire logic [LANE_W-1:0] lane_lsb_bits,
  output logic lock_status,
  output dpc_mode_t mode,
  output logic filter_en,
  output logic spread_clock_gen,
  output logic ssc_low_band,
  output logic [2:0] ssc_range,
  output logic rx_gain_boost,
  output logic lvds_swing,
  output logic [LANE_W-1:0] lvds_lane3,
  output logic lvds_lane3_oe,
  output logic lvds_clock_out_oe,
  output logic device_active
);

  dpc_state_t st_q, st_d;
  logic active;
  logic ovr;
  logic acc_wr;
  logic acc_rd;
  logic setup_rd;
  logic [2:0] ev_set;
  logic [2:0] ev_clr;
  logic [1:0] mode_bits;
  logic [31:0] rd_word;

  // pin value unless software override is set
  function automatic logic pick(input logic o, input logic r,
                                input logic p);
    pick = o ? r : p;
  endfunction : pick

  function automatic logic addr_known(input logic [`DPC_ADDR_W-1:0] a);
    addr_known = (a == `DPC_OFF_CTRL) || (a == `DPC_OFF_STATUS)
      || (a == `DPC_OFF_MASK) || (a == `DPC_OFF_STATE);
  endfunction : addr_known

  assign active = power_down_n;
  assign ovr = st_q.ctrl[`DPC_CTRL_OVR];
  assign acc_wr = psel && penable && pwrite;
  assign acc_rd = psel && penable && !pwrite;
  assign setup_rd = psel && !penable && !pwrite;

  dpc_lock_filt #(
    .SETTLE(SETTLE),
    .CNT_W(8)
  ) u_lock (
    .pclk(pclk),
    .presetn(presetn),
    .enable(active),
    .pll_locked(pll_locked),
    .lock_status(lock_status)
  );

  dpc_lane_map #(
    .W(LANE_W)
  ) u_map (
    .pclk(pclk),
    .presetn(presetn),
    .active(active),
    .msb_first(st_q.map),
    .msb_bits(lane_msb_bits),
    .lsb_bits(lane_lsb_bits),
    .lane3(lvds_lane3)
  );

  always_comb begin
    ev_set = '0;
    ev_set[`DPC_EV_LOCK_UP] = lock_status && !st_q.lock_prev;
    ev_set[`DPC_EV_LOCK_DOWN] = !lock_status && st_q.lock_prev;
    ev_set[`DPC_EV_SPARE] = active && spare_input_low;
    ev_clr = (acc_rd && paddr == `DPC_OFF_STATUS) ? 3'h7 : 3'h0;
    mode_bits[0] = pick(ovr, st_q.ctrl[`DPC_CTRL_MODE_LO], config_mode[0]);
    mode_bits[1] = pick(ovr, st_q.ctrl[`DPC_CTRL_MODE_HI], config_mode[1]);
    rd_word = 32'h0000_0000;
    if (paddr == `DPC_OFF_CTRL) begin
      rd_word[`DPC_CTRL_W-1:0] = st_q.ctrl;
    end else if (paddr == `DPC_OFF_STATUS) begin
      rd_word[`DPC_EV_W-1:0] = st_q.status;
    end else if (paddr == `DPC_OFF_MASK) begin
      rd_word[`DPC_EV_W-1:0] = st_q.mask;
    end else if (paddr == `DPC_OFF_STATE) begin
      rd_word[`DPC_ST_LOCK] = lock_status;
      rd_word[`DPC_ST_MODE_HI:`DPC_ST_MODE_LO] = st_q.mode;
      rd_word[`DPC_ST_BAND] = st_q.band;
      rd_word[`DPC_ST_MAP] = st_q.map;
      rd_word[`DPC_ST_SWING] = st_q.swing;
      rd_word[`DPC_ST_SSC] = st_q.ssc_en;
      rd_word[`DPC_ST_GAIN] = st_q.gain;
      rd_word[`DPC_ST_ACTIVE] = active;
      rd_word[`DPC_ST_OE] = st_q.data_oe;
    end
  end

  always_comb begin
    st_d = st_q;
    st_d.lock_prev = lock_status;
    // set wins over the read clear so an event raised in the access cycle is not lost
    st_d.status = (st_q.status & ~ev_clr) | ev_set;
    if (setup_rd) begin
      st_d.rdata = rd_word;
    end
    if (acc_wr && paddr == `DPC_OFF_CTRL) begin
      st_d.ctrl = pwdata[`DPC_CTRL_W-1:0];
    end else if (acc_wr && paddr == `DPC_OFF_MASK) begin
      st_d.mask = pwdata[`DPC_EV_W-1:0];
    end
    if (!active) begin
      st_d.ctrl = `DPC_CTRL_RST;
      st_d.mask = `DPC_MASK_RST;
    end
    // floating pins pulled low give mode 00, high band, lsb map
    st_d.mode = dpc_mode_t'(mode_bits);
    case (st_d.mode)
      DPC_MODE_CUR_NOFILT: st_d.filter_en = 1'b0;
      DPC_MODE_CUR_FILT: st_d.filter_en = 1'b1;
      DPC_MODE_LEGACY_A: st_d.filter_en = 1'b0;
      DPC_MODE_LEGACY_B: st_d.filter_en = 1'b0;
      default: st_d.filter_en = 1'b0;
    endcase
    st_d.band = pick(ovr, st_q.ctrl[`DPC_CTRL_BAND], low_freq_band);
    st_d.map = pick(ovr, st_q.ctrl[`DPC_CTRL_MAP], bit_map_order);
    st_d.swing = pick(ovr, st_q.ctrl[`DPC_CTRL_SWING], lvds_swing_select);
    st_d.ssc_range = spread_range_select;
    // a zero range code means spreading off
    st_d.ssc_en = active && !clk_above_65m
      && (spread_range_select != 3'h0);
    // unlocked outputs also need the sleep select to stay driven
    st_d.data_oe = active && output_enable_pin
      && (lock_status || sleep_state_select);
    if (!active) begin
      st_d.strap_done = 1'b0;
    end else if (!st_q.strap_done) begin
      st_d.gain = gain_pass_i;
      st_d.strap_done = 1'b1;
    end
    st_d.irq = |(st_d.status & st_d.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_known(paddr);
  assign irq = st_q.irq;
  assign mode = st_q.mode;
  assign filter_en = st_q.filter_en;
  assign spread_clock_gen = st_q.ssc_en;
  assign ssc_low_band = st_q.band;
  assign ssc_range = st_q.ssc_range;
  assign rx_gain_boost = st_q.gain;
  assign lvds_swing = st_q.swing;
  assign lvds_lane3_oe = st_q.data_oe;
  assign lvds_clock_out_oe = st_q.data_oe;
  assign device_active = active;
  // shared pin stays input until the strap is caught
  assign gain_pass_oe = st_q.strap_done;
  assign gain_pass_o = st_q.strap_done && bist_pass;

  property p_pd_resets_ctrl;
    @(posedge pclk) disable iff (!presetn)
      !power_down_n |=> st_q.ctrl == `DPC_CTRL_RST && st_q.mask == 3'h0;
  endproperty
  a_pd_resets_ctrl: assert property (p_pd_resets_ctrl)
    else $error("control registers survive power down");

  property p_pd_tristate;
    @(posedge pclk) disable iff (!presetn)
      !power_down_n |=> !lvds_lane3_oe && lvds_lane3 == '0;
  endproperty
  a_pd_tristate: assert property (p_pd_tristate)
    else $error("lvds lane driven while powered down");

  property p_filter_mode;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> filter_en == ($past(mode_bits) == 2'b01);
  endproperty
  a_filter_mode: assert property (p_filter_mode)
    else $error("filter enable disagrees with mode");

  property p_pin_mode;
    @(posedge pclk) disable iff (!presetn)
      !ovr |=> mode == dpc_mode_t'($past(config_mode));
  endproperty
  a_pin_mode: assert property (p_pin_mode)
    else $error("mode does not follow mode pins");

  property p_no_ssc_high;
    @(posedge pclk) disable iff (!presetn)
      clk_above_65m |=> !spread_clock_gen;
  endproperty
  a_no_ssc_high: assert property (p_no_ssc_high)
    else $error("spread spectrum on above 65 MHz");

  property p_band;
    @(posedge pclk) disable iff (!presetn)
      !ovr |=> ssc_low_band == $past(low_freq_band);
  endproperty
  a_band: assert property (p_band)
    else $error("band does not follow band pin");

  sequence s_pd_exit;
    !power_down_n ##1 power_down_n;
  endsequence
  sequence s_strap_caught(logic v);
    ##1 gain_pass_oe && rx_gain_boost == v;
  endsequence
  property p_strap;
    logic v;
    @(posedge pclk) disable iff (!presetn)
      (s_pd_exit, v = gain_pass_i) |-> !gain_pass_oe
        ##0 s_strap_caught(v);
  endproperty
  a_strap: assert property (p_strap)
    else $error("gain strap not latched before pin drives");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      $rose(lock_status) && st_q.mask[`DPC_EV_LOCK_UP] |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("lock rise did not raise interrupt");

  property p_oe_locked;
    @(posedge pclk) disable iff (!presetn)
      power_down_n && output_enable_pin && lock_status |=> lvds_lane3_oe;
  endproperty
  a_oe_locked: assert property (p_oe_locked)
    else $error("lvds outputs off while locked and enabled");

  property p_oe_unlocked;
    @(posedge pclk) disable iff (!presetn)
      !lock_status && !sleep_state_select |=> !lvds_lane3_oe;
  endproperty
  a_oe_unlocked: assert property (p_oe_unlocked)
    else $error("lvds outputs driven while unlocked without sleep select");

  property p_ssc_on;
    @(posedge pclk) disable iff (!presetn)
      power_down_n && !clk_above_65m && spread_range_select != 3'h0
        |=> spread_clock_gen && ssc_range == $past(spread_range_select);
  endproperty
  a_ssc_on: assert property (p_ssc_on)
    else $error("spread range not applied");

  property p_ovr_mode;
    @(posedge pclk) disable iff (!presetn)
      ovr |=> mode == dpc_mode_t'(
        $past(st_q.ctrl[`DPC_CTRL_MODE_HI:`DPC_CTRL_MODE_LO]));
  endproperty
  a_ovr_mode: assert property (p_ovr_mode)
    else $error("mode does not follow override register");

endmodule : dpc_top

// File: dv/dpc_ser_model.sv
/*
  companion serializer model: lock level and lane 3 bit groups.
  assumes pclk from the bench; link_en high marks a live serial link.
*/
`timescale 1ns/1ps

module dpc_ser_model #(
  parameter int LOCK_DLY = 5
) (
  input wire logic pclk,
  input wire logic link_en,
  input wire logic advance,
  output logic pll_locked,
  output logic [6:0] msb_bits,
  output logic [6:0] lsb_bits
);
  int cnt = 0;

  initial begin
    pll_locked = 1'b0;
    msb_bits = 7'h00;
    lsb_bits = 7'h7F;
  end

  // lock only after a settled link, lost at once
  always @(posedge pclk) begin
    cnt <= link_en ? ((cnt < LOCK_DLY) ? cnt + 1 : cnt) : 0;
    pll_locked <= link_en && (cnt == LOCK_DLY);
    if (!link_en) begin
      // dead link: no stale data, garbage every cycle
      msb_bits <= ~msb_bits;
      lsb_bits <= ~lsb_bits;
    end else if (advance) begin
      msb_bits <= 7'($urandom);
      lsb_bits <= 7'($urandom);
    end
  end
endmodule : dpc_ser_model

// File: dv/test_deser_pin_config_control.sv
/*
  self-checking bench of dpc_top with a serializer model.
  assumes the register map of dpc_regs.svh and zero wait state apb.
*/
`timescale 1ns/1ps
`include "dpc_regs.svh"

module test_deser_pin_config_control import dpc_pkg::*;;
  localparam int SETTLE = 10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] config_mode;
  logic [2:0] spread_range_select, ssc_range;
  logic low_freq_band, bit_map_order, output_enable_pin, er;
  logic sleep_state_select, power_down_n, spare_input_low, strap_lvl;
  logic lvds_swing_select, clk_above_65m, pll_locked, bist_pass;
  logic gain_pass_i, gain_pass_o, gain_pass_oe, lock_status, filter_en;
  logic spread_clock_gen, ssc_low_band, rx_gain_boost, lvds_swing;
  logic lvds_lane3_oe, lvds_clock_out_oe, device_active, link_en, advance;
  logic [6:0] lane_msb_bits, lane_lsb_bits, lvds_lane3;
  dpc_mode_t mode;
  int error_cnt = 0;
  int total_checks = 0;
  int n;

  // shared pin: device drives it once the strap is latched
  assign gain_pass_i = gain_pass_oe ? gain_pass_o : strap_lvl;

  dpc_top #(.LANE_W(7), .SETTLE(SETTLE)) dut (.pclk, .presetn, .paddr,
    .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .irq,
    .config_mode, .low_freq_band, .bit_map_order, .output_enable_pin,
    .sleep_state_select, .power_down_n, .spare_input_low,
    .spread_range_select, .lvds_swing_select, .clk_above_65m, .pll_locked,
    .bist_pass, .gain_pass_i, .gain_pass_o, .gain_pass_oe, .lane_msb_bits,
    .lane_lsb_bits, .lock_status, .mode, .filter_en, .spread_clock_gen,
    .ssc_low_band, .ssc_range, .rx_gain_boost, .lvds_swing, .lvds_lane3,
    .lvds_lane3_oe, .lvds_clock_out_oe, .device_active);

  dpc_ser_model #(.LOCK_DLY(5)) ser (.pclk, .link_en, .advance,
    .pll_locked, .msb_bits(lane_msb_bits), .lsb_bits(lane_lsb_bits));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic results();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int c);
    repeat (c) @(posedge pclk);
  endtask : tick

  // one transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      error_cnt++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  function automatic logic exp_oe(input logic lk);
    return power_down_n & output_enable_pin & (lk | sleep_state_select);
  endfunction : exp_oe

  initial begin
    {psel, penable, pwrite, low_freq_band, bit_map_order} = 5'h00;
    {output_enable_pin, sleep_state_select, power_down_n} = 3'h0;
    {spare_input_low, lvds_swing_select, clk_above_65m} = 3'h0;
    {bist_pass, strap_lvl, link_en, advance, presetn} = 5'h00;
    {paddr, pwdata, config_mode, spread_range_select} = 49'h0;
    n = $urandom(32'hCF53);
    tick(20);
    presetn <= 1'b1;
    tick(3);
    check(device_active, 0);
    check({mode, ssc_low_band, lvds_lane3_oe}, 0);
    strap_lvl <= 1'b1;
    power_down_n <= 1'b1;
    tick(2);
    strap_lvl <= 1'b0;
    tick(3);
    check(rx_gain_boost, 1);
    check(gain_pass_oe, 1);
    apb(1'b0, `DPC_OFF_CTRL, 0);
    check(rd, `DPC_CTRL_RST);
    apb(1'b0, 12'h010, 0);
    check(er, 1'b1);
    check(rd, 32'h0);
    apb(1'b1, `DPC_OFF_MASK, 32'h1);
    link_en <= 1'b1;
    n = 0;
    while (lock_status !== 1'b1 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    check(lock_status, 1);
    check(n >= SETTLE, 1);
    tick(2);
    check(irq, 1);
    apb(1'b0, `DPC_OFF_STATUS, 0);
    check(rd[2:0], 3'h1);
    check(irq, 0);
    // all four modes first, then random pin sets
    for (int i = 0; i < 24; i++) begin
      config_mode <= (i < 4) ? 2'(i) : 2'($urandom);
      {low_freq_band, bit_map_order, clk_above_65m} <= 3'($urandom);
      {output_enable_pin, sleep_state_select} <= 2'($urandom);
      {lvds_swing_select, bist_pass} <= 2'($urandom);
      spread_range_select <= 3'($urandom);
      advance <= 1'b1;
      @(posedge pclk);
      advance <= 1'b0;
      tick(3);
      check(mode, config_mode);
      check(filter_en, config_mode == 2'b01);
      check(ssc_low_band, low_freq_band);
      check(spread_clock_gen, |spread_range_select & !clk_above_65m);
      check(ssc_range, spread_range_select);
      check(lvds_lane3, bit_map_order ? lane_msb_bits : lane_lsb_bits);
      check(lvds_lane3_oe, exp_oe(1'b1));
      check(lvds_swing, lvds_swing_select);
      check(gain_pass_o, bist_pass);
    end
    output_enable_pin <= 1'b1;
    sleep_state_select <= 1'b0;
    link_en <= 1'b0;
    tick(4);
    check(lock_status, 0);
    check(lvds_lane3_oe, 0);
    check(irq, 0);
    sleep_state_select <= 1'b1;
    tick(3);
    check(lvds_lane3_oe, exp_oe(1'b0));
    apb(1'b0, `DPC_OFF_STATUS, 0);
    check(rd[2:0], 3'h2);
    // spare pin raised on purpose to see the event
    apb(1'b1, `DPC_OFF_MASK, 32'h4);
    spare_input_low <= 1'b1;
    @(posedge pclk);
    spare_input_low <= 1'b0;
    tick(3);
    check(irq, 1);
    apb(1'b0, `DPC_OFF_STATUS, 0);
    check(rd[2:0], 3'h4);
    check(irq, 0);
    apb(1'b1, `DPC_OFF_CTRL, 32'h3F);
    apb(1'b0, `DPC_OFF_CTRL, 0);
    check(rd, 32'h3F);
    check({mode, ssc_low_band, lvds_swing}, 4'hF);
    apb(1'b0, `DPC_OFF_STATE, 0);
    check(rd[9:0], {3'h7, |spread_range_select & !clk_above_65m,
      6'h3E});
    power_down_n <= 1'b0;
    tick(3);
    check(device_active, 0);
    check({lvds_lane3_oe, lvds_clock_out_oe, lvds_lane3}, 0);
    power_down_n <= 1'b1;
    tick(3);
    apb(1'b0, `DPC_OFF_CTRL, 0);
    check(rd, `DPC_CTRL_RST);
    apb(1'b0, `DPC_OFF_MASK, 0);
    check(rd, `DPC_MASK_RST);
    check(rx_gain_boost, 1'b0);
    results();
  end
endmodule : test_deser_pin_config_control
